// [shared/cdprb_pkg.sv]
// constants, types and helpers for the configurable dual-port ram block
package cdprb_pkg;
  localparam int ARRAY_BITS = 4608;
  localparam int LOGIC_BITS = 4096;
  localparam int ROW_W = 36;
  localparam int DW = 36;
  localparam int AW = 12;
  localparam int BW = 13;
  localparam int LINK_W = 10;
  localparam int LANES = 4;
  localparam int WCODES = 9;
  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_WIDTH = 8'h04;
  localparam logic [7:0] OFF_SHIFT = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_INIT_ADDR = 8'h10;
  localparam logic [7:0] OFF_INIT_HI = 8'h14;
  localparam logic [7:0] OFF_LINK = 8'h18;
  localparam logic [7:0] OFF_INIT_DATA = 8'h1c;
  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BYP_LSB = 3;
  localparam int CTRL_OSEL_LSB = 5;
  localparam int CTRL_ISEL_LSB = 7;
  localparam int WIDTH_A_LSB = 0;
  localparam int WIDTH_B_LSB = 4;
  localparam int SH_W_LSB = 0;
  localparam int SH_N_LSB = 6;
  localparam int SH_M_LSB = 12;
  localparam int ST_OK = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_CNT_LSB = 3;
  localparam int LINK_R_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WIDTH_RST = 32'h0000_0000;
  localparam logic [31:0] SHIFT_RST = 32'h0000_1041;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_TDP, MODE_SDP, MODE_SP, MODE_FIFO, MODE_ROM, MODE_SHIFT
  } cdprb_mode_t;

  typedef enum logic [3:0] {
    W1, W2, W4, W8, W16, W32, W9, W18, W36
  } cdprb_width_t;

  function automatic logic [5:0] wbits(logic [3:0] c);
    case (c)
      W1: wbits = 6'h01;
      W2: wbits = 6'h02;
      W4: wbits = 6'h04;
      W8: wbits = 6'h08;
      W16: wbits = 6'h10;
      W32: wbits = 6'h20;
      W9: wbits = 6'h09;
      W18: wbits = 6'h12;
      W36: wbits = 6'h24;
      default: wbits = 6'h01;
    endcase
  endfunction : wbits

  function automatic logic is_par(logic [3:0] c);
    is_par = (c == W9) || (c == W18) || (c == W36);
  endfunction : is_par

  // logical bit to array bit; plain widths skip the ninth bit of a lane
  function automatic logic [BW-1:0] phys(logic [BW-1:0] b, logic par);
    phys = par ? b : BW'(b[BW-1:5] * 36 + b[4:3] * 9 + b[2:0]);
  endfunction : phys

  function automatic logic [BW-1:0] depth(logic [3:0] c);
    depth = BW'((is_par(c) ? ARRAY_BITS : LOGIC_BITS) / wbits(c));
  endfunction : depth
endpackage : cdprb_pkg

// [rtl/cdprb_top.sv]
// configurable dual-port ram block with axi4-lite configuration slave
// What this block does
// - holds 4608 storage bits, parity bits included
// - runs as true dual, simple dual, single port, fifo, rom or shift
// - ram and rom contents can be preloaded before use
// - shapes 4096x1 through 128x36 are supported
// - 128-deep shapes are refused in true dual-port mode
// - simple dual-port pairs plain widths freely, parity widths among themselves
// - true dual-port pairs 1..16 freely, 9 and 18 only together
// - shift register width times length times taps stays within 4608
// - lane masking applies only to 16, 18, 32 and 36 bit writes
// - masked-off lanes keep their stored content
// - mask bits gate 9-bit lanes from bit 0 upward
// - any mix of mask bits works, each lane on its own
// - in 16 and 32 bit widths each mask bit gates one byte
// - input and output registers may follow either port clock
// - inputs always registered; only the output register may be bypassed
// - ten direct-link inputs and outputs on each side
// - shift mode reads old contents then writes, advancing each clock
// - write select chooses whether a port writes outside shift mode; a port that can read also loads its output on write clocks
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module cdprb_top import cdprb_pkg::*; (
  input wire logic core_clk_i, // 10 mhz core clock
  input wire logic sys_rst_i, // synchronous reset, high
  input wire logic [7:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [7:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic a_clk_i, // port a clock pin
  input wire logic a_clken_i, // port a clock enable
  input wire logic a_wren_i, // port a write select
  input wire logic a_clr_i, // port a output clear
  input wire logic [AW-1:0] a_addr_i, // port a address
  input wire logic [DW-1:0] a_data_i, // port a write data
  input wire logic [LANES-1:0] a_lane_i, // port a lane mask
  output logic [DW-1:0] a_q_o, // port a read data
  input wire logic b_clk_i, // port b clock pin
  input wire logic b_clken_i, // port b clock enable
  input wire logic b_wren_i, // port b write select
  input wire logic b_clr_i, // port b output clear
  input wire logic [AW-1:0] b_addr_i, // port b address
  input wire logic [DW-1:0] b_data_i, // port b write data
  input wire logic [LANES-1:0] b_lane_i, // port b lane mask
  output logic [DW-1:0] b_q_o, // port b read data or taps
  input wire logic [LINK_W-1:0] link_left_i, // left logic_cluster link
  input wire logic [LINK_W-1:0] link_right_i, // right logic_cluster link
  output logic [LINK_W-1:0] link_left_o, // to left logic_cluster
  output logic [LINK_W-1:0] link_right_o // to right logic_cluster
);
  localparam int PV = 4 + AW + DW + LANES;

  logic [PV-1:0] pin_s1 [2];
  logic [PV-1:0] pin_s2 [2];
  logic [2*LINK_W-1:0] link_s1, link_s2;
  logic [1:0] clk_d, p_en, p_we, p_clr, p_edge, in_stb, out_stb;
  logic [1:0] isel, osel, byp, go_r, we_r, can_wr, can_rd;
  logic [AW-1:0] addr_r [2];
  logic [DW-1:0] data_r [2];
  logic [LANES-1:0] mask_r [2];
  logic [DW-1:0] q [2];
  logic [DW-1:0] rd_word [2];
  logic [BW-1:0] wr_base [2];
  logic [BW-1:0] rd_base [2];
  logic [5:0] wr_w [2];
  logic [LANES-1:0] wr_lanes [2];
  logic [1:0] wr_en, wr_par;
  logic [ARRAY_BITS-1:0] mem;
  logic [31:0] ctrl, width, shift;
  logic [6:0] init_addr;
  logic [3:0] init_hi;
  logic [3:0] wc [2];
  cdprb_mode_t mode;
  logic cfg_ok, init_go, push, pop, full, empty, sh_go;
  logic [BW-1:0] fifo_dep, fcnt, wptr, rptr, sh_ptr, sh_len;
  logic [5:0] sh_w, sh_n;
  logic [BW-1:0] sh_m;
  logic [DW-1:0] tap_word;
  logic aw_got, w_got, wr_fire;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin : pin_sync
    if (sys_rst_i) begin
      pin_s1[0] <= '0;
      pin_s1[1] <= '0;
      pin_s2[0] <= '0;
      pin_s2[1] <= '0;
      link_s1 <= '0;
      link_s2 <= '0;
      clk_d <= '0;
    end else begin
      pin_s1[0] <= {a_clk_i, a_clken_i, a_wren_i, a_clr_i, a_addr_i,
                    a_data_i, a_lane_i};
      pin_s1[1] <= {b_clk_i, b_clken_i, b_wren_i, b_clr_i, b_addr_i,
                    b_data_i, b_lane_i};
      pin_s2[0] <= pin_s1[0];
      pin_s2[1] <= pin_s1[1];
      link_s1 <= {link_right_i, link_left_i};
      link_s2 <= link_s1;
      clk_d <= {pin_s2[1][PV-1], pin_s2[0][PV-1]};
    end
  end

  assign mode = cdprb_mode_t'(ctrl[CTRL_MODE_LSB +: 3]);
  assign wc[0] = width[WIDTH_A_LSB +: 4];
  assign wc[1] = width[WIDTH_B_LSB +: 4];
  assign sh_w = shift[SH_W_LSB +: 6];
  assign sh_n = shift[SH_N_LSB +: 6];
  assign sh_m = shift[SH_M_LSB +: BW];
  assign sh_len = BW'(sh_m * sh_n);
  assign fifo_dep = depth(wc[0]);

  function automatic logic cfg_check(cdprb_mode_t md, logic [3:0] ca,
                                     logic [3:0] cb);
    logic vab;
    vab = (ca < WCODES) && (cb < WCODES) && (is_par(ca) == is_par(cb));
    case (md)
      MODE_TDP: cfg_check = vab && ca != W32 && ca != W36 &&
                            cb != W32 && cb != W36;
      MODE_SDP: cfg_check = vab;
      MODE_SP, MODE_FIFO, MODE_ROM: cfg_check = ca < WCODES;
      MODE_SHIFT: cfg_check = sh_w != 0 && sh_n != 0 && sh_m != 0 &&
                  32'(sh_w) * 32'(sh_len) <= ARRAY_BITS &&
                  32'(sh_w) * 32'(sh_n) <= DW;
      default: cfg_check = 1'b0;
    endcase
  endfunction : cfg_check

  function automatic logic [DW-1:0] rd(logic [ARRAY_BITS-1:0] m,
                                       logic [BW-1:0] base, logic [5:0] w,
                                       logic par);
    logic [BW-1:0] idx;
    rd = '0;
    for (int k = 0; k < DW; k++) begin
      idx = phys(BW'(base + BW'(k)), par);
      if (k < w && idx < ARRAY_BITS) rd[k] = m[idx];
    end
  endfunction : rd

  // shift fields are read inside the function, so a process sees them
  always_comb cfg_ok = cfg_check(mode, wc[0], wc[1]);
  assign full = fcnt == fifo_dep;
  assign empty = fcnt == '0;
  assign push = mode == MODE_FIFO && cfg_ok && go_r[0] && we_r[0] && !full;
  assign pop = mode == MODE_FIFO && cfg_ok && go_r[1] && !we_r[1] && !empty;
  assign sh_go = mode == MODE_SHIFT && cfg_ok && go_r[0];

  // ****************************************************************
  // port control and input registers
  // ****************************************************************
  always_comb begin : port_ctl
    for (int p = 0; p < 2; p++) begin
      p_en[p] = pin_s2[p][PV-2];
      p_we[p] = pin_s2[p][PV-3];
      p_clr[p] = pin_s2[p][PV-4];
      p_edge[p] = pin_s2[p][PV-1] && !clk_d[p];
      isel[p] = ctrl[CTRL_ISEL_LSB + p];
      osel[p] = ctrl[CTRL_OSEL_LSB + p];
      byp[p] = ctrl[CTRL_BYP_LSB + p];
      in_stb[p] = isel[p] ? p_edge[1-p] : p_edge[p];
      out_stb[p] = osel[p] ? p_edge[1-p] : p_edge[p];
    end
    can_wr[0] = cfg_ok && (mode == MODE_TDP || mode == MODE_SDP ||
                           mode == MODE_SP);
    can_wr[1] = cfg_ok && mode == MODE_TDP;
    can_rd[0] = cfg_ok && (mode == MODE_TDP || mode == MODE_SP ||
                           mode == MODE_ROM);
    can_rd[1] = cfg_ok && (mode == MODE_TDP || mode == MODE_SDP);
  end

  always_ff @(posedge core_clk_i) begin : in_regs
    for (int p = 0; p < 2; p++) begin
      if (sys_rst_i) begin
        go_r[p] <= 1'b0;
        we_r[p] <= 1'b0;
        addr_r[p] <= '0;
        data_r[p] <= '0;
        mask_r[p] <= '0;
      end else begin
        go_r[p] <= in_stb[p] && p_en[p];
        if (in_stb[p] && p_en[p]) begin
          we_r[p] <= p_we[p];
          addr_r[p] <= pin_s2[p][PV-5 -: AW] &
                       AW'(depth(wc[p]) - BW'(1));
          data_r[p] <= pin_s2[p][LANES +: DW];
          mask_r[p] <= pin_s2[p][LANES-1:0];
        end
      end
    end
  end

  // ****************************************************************
  // write and read address generation
  // ****************************************************************
  always_comb begin : addr_gen
    for (int p = 0; p < 2; p++) begin
      wr_en[p] = go_r[p] && we_r[p] && can_wr[p];
      wr_base[p] = BW'(addr_r[p] * wbits(wc[p]));
      wr_w[p] = wbits(wc[p]);
      wr_par[p] = is_par(wc[p]);
      wr_lanes[p] = wr_w[p] >= 6'h10 ? mask_r[p] : '1;
      rd_base[p] = BW'(addr_r[p] * wbits(wc[p]));
    end
    if (push) begin
      wr_en[0] = 1'b1;
      wr_base[0] = BW'(wptr * wbits(wc[0]));
    end
    if (sh_go) begin
      wr_en[0] = 1'b1;
      wr_base[0] = BW'(sh_ptr * sh_w);
      wr_w[0] = sh_w;
      wr_par[0] = 1'b1;
      wr_lanes[0] = '1;
    end
    rd_base[1] = mode == MODE_FIFO ? BW'(rptr * wbits(wc[0])) : rd_base[1];
    rd_word[0] = rd(mem, rd_base[0], wbits(wc[0]), is_par(wc[0]));
    rd_word[1] = mode == MODE_FIFO ?
                 rd(mem, rd_base[1], wbits(wc[0]), is_par(wc[0])) :
                 rd(mem, rd_base[1], wbits(wc[1]), is_par(wc[1]));
  end

  // ****************************************************************
  // storage array
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin : array_wr
    logic [BW-1:0] idx;
    logic [1:0] ln;
    if (init_go) begin
      mem[init_addr * ROW_W +: ROW_W] <= {init_hi, w_q};
    end else begin
      // port a goes last so it wins a same-address collision
      for (int p = 1; p >= 0; p--) begin
        for (int k = 0; k < DW; k++) begin
          idx = phys(BW'(wr_base[p] + BW'(k)), wr_par[p]);
          ln = wr_par[p] ? 2'(k / 9) : 2'(k / 8);
          if (wr_en[p] && k < wr_w[p] && wr_lanes[p][ln] &&
              idx < ARRAY_BITS) begin
            mem[idx] <= data_r[p][k];
          end
        end
      end
    end
  end

  // ****************************************************************
  // fifo pointers and shift register taps
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin : fifo_ptr
    if (sys_rst_i || mode != MODE_FIFO) begin
      wptr <= '0;
      rptr <= '0;
      fcnt <= '0;
    end else begin
      if (push) wptr <= wptr + 1'b1 == fifo_dep ? '0 : wptr + 1'b1;
      if (pop) rptr <= rptr + 1'b1 == fifo_dep ? '0 : rptr + 1'b1;
      fcnt <= fcnt + BW'(push) - BW'(pop);
    end
  end

  always_ff @(posedge core_clk_i) begin : shift_ptr
    if (sys_rst_i || mode != MODE_SHIFT) begin
      sh_ptr <= '0;
    end else if (sh_go) begin
      sh_ptr <= sh_ptr + 1'b1 == sh_len ? '0 : sh_ptr + 1'b1;
    end
  end

  // taps read the old word before the write at the same edge lands
  always_comb begin : taps
    int t;
    int idx;
    tap_word = '0;
    t = 0;
    idx = 0;
    for (int j = 0; j < DW; j++) begin
      t = sh_w == 0 ? DW : j / int'(sh_w);
      if (t < sh_n) begin
        idx = int'(sh_ptr) + int'(sh_len) - (t + 1) * int'(sh_m);
        if (idx >= int'(sh_len)) idx = idx - int'(sh_len);
        idx = idx * int'(sh_w) + j % int'(sh_w);
        if (idx >= 0 && idx < ARRAY_BITS) tap_word[j] = mem[idx];
      end
    end
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  always_ff @(posedge core_clk_i) begin : out_regs
    for (int p = 0; p < 2; p++) begin
      if (sys_rst_i || p_clr[p]) begin
        q[p] <= '0;
      end else if (p == 1 && sh_go) begin
        q[p] <= tap_word;
      end else if (p == 1 && pop) begin
        q[p] <= rd_word[p];
      end else if (out_stb[p] && p_en[p] && can_rd[p]) begin
        q[p] <= rd_word[p];
      end
    end
  end

  assign a_q_o = byp[0] && can_rd[0] ? rd_word[0] : q[0];
  assign b_q_o = byp[1] && can_rd[1] ? rd_word[1] : q[1];
  assign link_left_o = q[0][LINK_W-1:0];
  assign link_right_o = q[1][LINK_W-1:0];

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d,
                                        logic [3:0] s);
    for (int i = 0; i < 4; i++) merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] :
                                                       o[i*8 +: 8];
  endfunction : merge

  function automatic logic mapped(logic [7:0] a);
    mapped = {a[7:2], 2'b00} <= OFF_INIT_DATA;
  endfunction : mapped

  assign s_axi_awready_o = !aw_got && !s_axi_bvalid_o;
  assign s_axi_wready_o = !w_got && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign wr_fire = aw_got && w_got;
  assign init_go = wr_fire && {aw_q[7:2], 2'b00} == OFF_INIT_DATA &&
                   (mode != MODE_FIFO && mode != MODE_SHIFT);

  always_ff @(posedge core_clk_i) begin : axi_wr
    if (sys_rst_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      s_q <= '0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got <= 1'b1;
        aw_q <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got <= 1'b1;
        w_q <= s_axi_wdata_i;
        s_q <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin : cfg_regs
    if (sys_rst_i) begin
      ctrl <= CTRL_RST;
      width <= WIDTH_RST;
      shift <= SHIFT_RST;
      init_addr <= '0;
      init_hi <= '0;
    end else if (wr_fire) begin
      case ({aw_q[7:2], 2'b00})
        OFF_CTRL: ctrl <= merge(ctrl, w_q, s_q) & 32'h0000_01ff;
        OFF_WIDTH: width <= merge(width, w_q, s_q) & 32'h0000_00ff;
        OFF_SHIFT: shift <= merge(shift, w_q, s_q) & 32'h01ff_ffff;
        OFF_INIT_ADDR: init_addr <= w_q[6:0];
        OFF_INIT_HI: init_hi <= w_q[3:0];
        OFF_INIT_DATA: init_addr <= init_go ? init_addr + 1'b1 : init_addr;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin : axi_rd
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      case ({s_axi_araddr_i[7:2], 2'b00})
        OFF_CTRL: s_axi_rdata_o <= ctrl;
        OFF_WIDTH: s_axi_rdata_o <= width;
        OFF_SHIFT: s_axi_rdata_o <= shift;
        OFF_STATUS: s_axi_rdata_o <= 32'(fcnt) << ST_CNT_LSB |
          32'(full) << ST_FULL | 32'(empty) << ST_EMPTY |
          32'(cfg_ok) << ST_OK;
        OFF_INIT_ADDR: s_axi_rdata_o <= 32'(init_addr);
        OFF_INIT_HI: s_axi_rdata_o <= 32'(init_hi);
        OFF_LINK: s_axi_rdata_o <= 32'(link_s2[LINK_W +: LINK_W]) <<
          LINK_R_LSB | 32'(link_s2[LINK_W-1:0]);
        OFF_INIT_DATA: s_axi_rdata_o <= mem[init_addr * ROW_W +: 32];
        default: s_axi_rdata_o <= '0;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule : cdprb_top

// [test/cdprb_fab.sv]
// fabric-side model driving one memory port
`timescale 1ns/1ps
module cdprb_fab import cdprb_pkg::*; (
  input wire logic core_clk_i, // core clock
  output logic clk_o = 1'b0, // port clock
  output logic clken_o = 1'b0, // clock enable
  output logic wren_o = 1'b0, // write select
  output logic clr_o = 1'b0, // output clear
  output logic [AW-1:0] addr_o = '0, // address
  output logic [DW-1:0] data_o = '0, // write data
  output logic [LANES-1:0] lane_o = '0 // lane mask
);
  // one port cycle; clock stands low outside it
  task op(input logic w, input logic en, input logic [AW-1:0] a,
          input logic [DW-1:0] d, input logic [LANES-1:0] ln);
    wren_o <= w;
    clken_o <= en;
    addr_o <= a;
    data_o <= d;
    lane_o <= ln;
    repeat (4) @(posedge core_clk_i);
    clk_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    clk_o <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    data_o <= ~d; // released bus shows no stale value
    @(posedge core_clk_i);
  endtask : op
  task clr();
    clr_o <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    clr_o <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask : clr
endmodule : cdprb_fab

// [test/cdprb_chk_asserts.sv]
// axi-lite handshake checker for the ram block
`timescale 1ns/1ps
module cdprb_chk import cdprb_pkg::*; (
  input wire logic core_clk_i, // clock
  input wire logic sys_rst_i, // reset
  input wire logic s_axi_awvalid_i, // aw
  input wire logic s_axi_awready_o, // aw
  input wire logic s_axi_wvalid_i, // w
  input wire logic s_axi_wready_o, // w
  input wire logic [1:0] s_axi_bresp_o, // b
  input wire logic s_axi_bvalid_o, // b
  input wire logic s_axi_bready_i, // b
  input wire logic [7:0] s_axi_araddr_i, // ar
  input wire logic s_axi_arvalid_i, // ar
  input wire logic s_axi_arready_o, // ar
  input wire logic [31:0] s_axi_rdata_o, // r
  input wire logic [1:0] s_axi_rresp_o, // r
  input wire logic s_axi_rvalid_o, // r
  input wire logic s_axi_rready_i // r
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  b_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("b dropped");
  r_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("r dropped");
  wr_block_a: assert property (
    s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken during response");
  rd_block_a: assert property (
    s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read overlap");
  rd_answer_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] <= 6'h07 |=>
    s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY) else $error("read late");
  rd_unmapped_a: assert property (
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] > 6'h07 |=>
    s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0)
    else $error("unmapped read not refused");
  wr_answer_a: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |-> ##[1:2] s_axi_bvalid_o) else $error("write response late");
  b_done_a: assert property (
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("response repeated");
endmodule : cdprb_chk
bind cdprb_top cdprb_chk cdprb_chk_i (.core_clk_i, .sys_rst_i,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i);

// [test/tb.sv]
// self-checking bench for the ram block
`timescale 1ns/1ps
module tb import cdprb_pkg::*;;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1;
  logic [7:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, rd;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rr;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, s_axi_awready_o;
  logic s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic a_clk_i, a_clken_i, a_wren_i, a_clr_i;
  logic b_clk_i, b_clken_i, b_wren_i, b_clr_i;
  logic [AW-1:0] a_addr_i, b_addr_i;
  logic [DW-1:0] a_data_i, b_data_i, a_q_o, b_q_o;
  logic [LANES-1:0] a_lane_i, b_lane_i;
  logic [LINK_W-1:0] link_left_i = '0, link_right_i = '0;
  logic [LINK_W-1:0] link_left_o, link_right_o;
  int bad_count = 0, tests_run = 0;
  // {ok, width b, width a, mode}
  localparam logic [12:0] CFG [11] = '{13'h0880, 13'h1881, 13'h0381,
    13'h1051, 13'h1760, 13'h0460, 13'h1040, 13'h1332, 13'h1333,
    13'h1334, 13'h1005};
  localparam logic [35:0] LM = 36'h0_07fc_01ff;
  cdprb_top cdprb_top_i (.*);
  cdprb_fab fab_a (.core_clk_i, .clk_o(a_clk_i), .clken_o(a_clken_i),
    .wren_o(a_wren_i), .clr_o(a_clr_i), .addr_o(a_addr_i),
    .data_o(a_data_i), .lane_o(a_lane_i));
  cdprb_fab fab_b (.core_clk_i, .clk_o(b_clk_i), .clken_o(b_clken_i),
    .wren_o(b_wren_i), .clr_o(b_clr_i), .addr_o(b_addr_i),
    .data_o(b_data_i), .lane_o(b_lane_i));
  always #50 core_clk_i = ~core_clk_i;
  task automatic chk(input string n, input logic [35:0] g, e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ka, kw, kb;
    int n;
    kb = 1'b0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (n = 0; n < 50 && !kb; n++) begin
      @(negedge core_clk_i);
      ka = s_axi_awready_o;
      kw = s_axi_wready_o;
      kb = s_axi_bvalid_o;
      rr = s_axi_bresp_o;
      @(posedge core_clk_i);
      if (ka) s_axi_awvalid_i <= 1'b0;
      if (kw) s_axi_wvalid_i <= 1'b0;
      if (kb) s_axi_bready_i <= 1'b0;
    end
    @(posedge core_clk_i);
    if (!kb) begin
      chk("write timeout", 36'h1, 36'h0);
      give_verdict();
    end
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic ka, kb;
    int n;
    kb = 1'b0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (n = 0; n < 50 && !kb; n++) begin
      @(negedge core_clk_i);
      ka = s_axi_arready_o;
      kb = s_axi_rvalid_o;
      rd = s_axi_rdata_o;
      rr = s_axi_rresp_o;
      @(posedge core_clk_i);
      if (ka) s_axi_arvalid_i <= 1'b0;
      if (kb) s_axi_rready_i <= 1'b0;
    end
    @(posedge core_clk_i);
    if (!kb) begin
      chk("read timeout", 36'h1, 36'h0);
      give_verdict();
    end
  endtask : axr
  task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
    axr(a);
    chk(n, 36'(rd), 36'(e));
  endtask : rc
  task automatic cfg(input logic [31:0] c, w);
    axw(OFF_CTRL, c);
    axw(OFF_WIDTH, w);
  endtask : cfg
  // q trails the captured address by one port clock
  task automatic prd(input logic pb, input logic [AW-1:0] a);
    repeat (2) begin
      if (pb) fab_b.op(1'b0, 1'b1, a, '0, '0);
      else fab_a.op(1'b0, 1'b1, a, '0, '0);
    end
  endtask : prd
  initial begin
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    rc(OFF_CTRL, CTRL_RST, "ctrl");
    rc(OFF_WIDTH, WIDTH_RST, "width");
    rc(OFF_SHIFT, SHIFT_RST, "shift");
    axr(8'h20);
    chk("unmapped", 36'(rr), 36'(RESP_SLVERR));
    for (int i = 0; i < 11; i++) begin
      cfg(32'(CFG[i][3:0]), 32'(CFG[i][11:4]));
      axr(OFF_STATUS);
      chk("cfg ok", 36'(rd[ST_OK]), 36'(CFG[i][12]));
    end
    axw(OFF_SHIFT, 32'h0008_0064);
    rc(OFF_STATUS, 32'h3, "shift fits");
    axw(OFF_SHIFT, 32'h0008_1064);
    rc(OFF_STATUS, 32'h2, "shift over");
    cfg(32'h1, 32'h88);
    fab_a.op(1'b1, 1'b1, 12'h003, 36'h9_aaaa_5555, 4'hf);
    fab_a.op(1'b1, 1'b1, 12'h003, 36'h6_1234_5678, 4'h5);
    fab_a.op(1'b1, 1'b0, 12'h003, 36'h0, 4'hf);
    prd(1'b1, 12'h003);
    chk("lanes", b_q_o, (36'h6_1234_5678 & LM) | (36'h9_aaaa_5555 & ~LM));
    cfg(32'h0, 32'h44);
    fab_a.op(1'b1, 1'b1, 12'h002, 36'h1234, 4'h3);
    fab_a.op(1'b1, 1'b1, 12'h002, 36'habcd, 4'h2);
    prd(1'b0, 12'h002);
    chk("byte lane", 36'(a_q_o[15:0]), 36'hab34);
    chk("link out", 36'(link_left_o), 36'h334);
    cfg(32'h0, 32'h33);
    fab_a.op(1'b1, 1'b1, 12'h007, 36'h5a, 4'h0);
    prd(1'b1, 12'h007);
    chk("no mask", 36'(b_q_o[7:0]), 36'h5a);
    chk("link right", 36'(link_right_o), 36'h05a);
    axw(OFF_INIT_ADDR, 32'h5);
    axw(OFF_INIT_HI, 32'h9);
    axw(OFF_INIT_DATA, 32'hc3a5_0f1e);
    rc(OFF_INIT_ADDR, 32'h6, "init step");
    axw(OFF_INIT_ADDR, 32'h5);
    rc(OFF_INIT_DATA, 32'hc3a5_0f1e, "init row");
    fab_b.clr();
    chk("clear", b_q_o, 36'h0);
    link_left_i <= 10'h2a5;
    link_right_i <= 10'h15a;
    repeat (3) @(posedge core_clk_i);
    rc(OFF_LINK, 32'h015a_02a5, "link in");
    give_verdict();
  end
endmodule : tb
